// file: alu_pkg.sv
// constants and types shared by the nibble exchange / xor datapath
package alu_pkg;
  localparam int DATA_WIDTH = 8;
  localparam int ADDR_WIDTH = 7;
  localparam int NIBBLE_WIDTH = 4;
  localparam logic [7:0] ACCUM_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'b0;
  localparam logic DEST_ACCUM = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  typedef enum logic [1:0]
  {
    op_none,
    nibble_exchange_op,
    accum_file_xor_op,
    accum_literal_xor_op
  } op_t;

  typedef enum logic [1:0]
  {
    idle_st,
    fetch_st,
    write_st
  } state_t;
endpackage

// file: result_unit.sv
// combinational result and zero detection for the three operations
`timescale 1ns/1ps
module result_unit
  import alu_pkg::*;
#(
  parameter int WIDTH = alu_pkg::DATA_WIDTH
)
(
  input wire alu_pkg::op_t op,
  input wire logic [WIDTH-1:0] accum,
  input wire logic [WIDTH-1:0] operand,
  output logic [WIDTH-1:0] result,
  output logic result_zero
);
  import alu_pkg::*;

  always_comb
  begin
    case (op)
      nibble_exchange_op: result = {operand[NIBBLE_WIDTH-1:0], operand[WIDTH-1:NIBBLE_WIDTH]};
      accum_file_xor_op: result = accum ^ operand;
      accum_literal_xor_op: result = accum ^ operand;
      default: result = operand;
    endcase
  end

  assign result_zero = (result == '0);
endmodule // result_unit

// file: nibble_swap_xor_alu.sv
// datapath slice executing nibble exchange, file xor and literal xor
`timescale 1ns/1ps
module nibble_swap_xor_alu
  import alu_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic start,
  input wire alu_pkg::op_t op,
  input wire logic dest,
  input wire logic [alu_pkg::ADDR_WIDTH-1:0] file_addr,
  input wire logic [alu_pkg::DATA_WIDTH-1:0] literal,
  output logic busy,
  output logic done,
  output logic file_rd_en,
  output logic [alu_pkg::ADDR_WIDTH-1:0] file_rd_addr,
  input wire logic [alu_pkg::DATA_WIDTH-1:0] file_rd_data,
  output logic file_wr_en,
  output logic [alu_pkg::ADDR_WIDTH-1:0] file_wr_addr,
  output logic [alu_pkg::DATA_WIDTH-1:0] file_wr_data,
  output logic [alu_pkg::DATA_WIDTH-1:0] accum,
  output logic zero_flag
);
  import alu_pkg::*;

  state_t state;
  op_t held_op;
  logic held_dest;
  logic [ADDR_WIDTH-1:0] held_addr;
  logic [DATA_WIDTH-1:0] held_operand;
  logic [DATA_WIDTH-1:0] result;
  logic result_zero;
  logic accept;
  logic uses_file;
  logic forward;
  logic write_accum;
  logic write_file;

  // a request names a real operation
  function automatic logic op_valid(
    input op_t code
  );
    return code != op_none;
  endfunction

  // operations that take their operand from the file array
  function automatic logic needs_file(
    input op_t code
  );
    return (code == nibble_exchange_op) || (code == accum_file_xor_op);
  endfunction

  // final destination; the literal form always lands in the accumulator
  function automatic logic route_of(
    input op_t code,
    input logic dest_bit
  );
    return (code == accum_literal_xor_op) ? DEST_ACCUM : dest_bit;
  endfunction

  // only the two xor forms touch the zero flag
  function automatic logic sets_zero(
    input op_t code
  );
    return (code == accum_file_xor_op) || (code == accum_literal_xor_op);
  endfunction

  // write-back of the held operation lands in the given place this cycle
  function automatic logic lands_in(
    input state_t now,
    input logic route,
    input logic place
  );
    return (now == write_st) && (route == place);
  endfunction

  assign accept = start && (state == idle_st) && op_valid(op);
  assign uses_file = needs_file(op);
  assign busy = (state != idle_st);
  assign write_accum = lands_in(state, held_dest, DEST_ACCUM);
  assign write_file = lands_in(state, held_dest, DEST_FILE);

  // file read is issued combinationally, data is taken the next cycle
  assign file_rd_en = accept && uses_file;
  assign file_rd_addr = file_addr;

  // file operations walk idle, fetch, write; the literal form skips fetch
  // while not idle a new start is ignored, busy tells the decoder so
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      state <= idle_st;
    else
    begin
      case (state)
        idle_st:
        begin
          if (accept)
            state <= uses_file ? fetch_st : write_st;
        end
        fetch_st:
        begin
          // operand arrives from the array in this cycle
          state <= write_st;
        end
        write_st:
        begin
          // result lands in this cycle
          state <= idle_st;
        end
        default: state <= idle_st;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      held_op <= op_none;
    else if (accept)
      held_op <= op;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      held_dest <= DEST_ACCUM;
    else if (accept)
      held_dest <= route_of(op, dest);
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      held_addr <= '0;
    else if (accept)
      held_addr <= file_addr;
  end

  // the array reads and writes on one edge, so a read of the slot being
  // written returns the old word; remember such a hit for the fetch cycle
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      forward <= 1'b0;
    else if (accept)
      forward <= file_wr_en && (file_wr_addr == file_addr);
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      held_operand <= '0;
    else if (accept)
      held_operand <= literal;
    else if (state == fetch_st)
      held_operand <= forward ? file_wr_data : file_rd_data;
  end

  result_unit #(
    .WIDTH(DATA_WIDTH)
  ) u_result (
    .op(held_op),
    .accum(accum),
    .operand(held_operand),
    .result(result),
    .result_zero(result_zero)
  );

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      accum <= ACCUM_RESET;
    else if (write_accum)
      accum <= result;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      file_wr_en <= 1'b0;
    else
      file_wr_en <= write_file;
  end

  // address and data stand until the next file write
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      file_wr_addr <= '0;
    else if (write_file)
      file_wr_addr <= held_addr;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      file_wr_data <= '0;
    else if (write_file)
      file_wr_data <= result;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      zero_flag <= ZERO_RESET;
    else if ((state == write_st) && sets_zero(held_op))
      zero_flag <= result_zero;
  end

  // one-cycle completion pulse, the block is idle again
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      done <= 1'b0;
    else
      done <= (state == write_st);
  end
endmodule // nibble_swap_xor_alu

// file: alu_chk_sva.sv
// port assertions for the datapath
`timescale 1ns/1ps
module alu_chk (
  input clock, reset, start, dest, busy, zero_flag, file_wr_en,
  input alu_pkg::op_t op,
  input [6:0] file_addr, file_wr_addr,
  input [7:0] literal, file_rd_data, file_wr_data, accum
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // accepted request, operation and destination
  wire [3:0] c = {start && !busy, op, dest};
  wire [7:0] a = accum, w = file_wr_data;
  // a read meeting a pending write of the same slot must see the new word
  logic hit;
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      hit <= 1'b0;
    else
      hit <= file_wr_en && (file_wr_addr == file_addr);
  end
  wire [7:0] d = hit ? w : file_rd_data;
  property p_swf; c == 4'hB |-> ##3 {w[3:0], w[7:4]} == $past(d, 2); endproperty
  a_swf: assert property (p_swf) else $error("swap to file");
  property p_swa; c == 4'hA |-> ##3 {a[3:0], a[7:4]} == $past(d, 2) && $stable(zero_flag);
  endproperty
  a_swa: assert property (p_swa) else $error("swap to accum");
  property p_xf; c == 4'hD |-> ##3 w == ($past(a, 3) ^ $past(d, 2)); endproperty
  a_xf: assert property (p_xf) else $error("xor to file");
  property p_xa; c == 4'hC |-> ##3 a == ($past(a, 3) ^ $past(d, 2)); endproperty
  a_xa: assert property (p_xa) else $error("xor to accum");
  property p_wa; (c == 4'hB || c == 4'hD) |->
    ##3 file_wr_en && file_wr_addr == $past(file_addr, 3);
  endproperty
  a_wa: assert property (p_wa) else $error("file write address");
  property p_xl; c[3:1] == 3'h7 |-> ##2 a == ($past(a, 2) ^ $past(literal, 2)); endproperty
  a_xl: assert property (p_xl) else $error("literal xor");
  property p_nl; c[3:1] == 3'h7 |-> ##2 !file_wr_en; endproperty
  a_nl: assert property (p_nl) else $error("literal wrote file");
  property p_z; c[3:1] == 3'h7 |-> ##2 zero_flag == (a == 8'h00); endproperty
  a_z: assert property (p_z) else $error("zero flag");
  cover property (c == 4'hB);
  cover property (c == 4'hD);
  cover property (c[3:1] == 3'h7 ##2 zero_flag);
endmodule // alu_chk
bind nibble_swap_xor_alu alu_chk u_alu_chk (
  .clock(clock),
  .reset(reset),
  .start(start),
  .dest(dest),
  .busy(busy),
  .zero_flag(zero_flag),
  .file_wr_en(file_wr_en),
  .op(op),
  .file_addr(file_addr),
  .file_wr_addr(file_wr_addr),
  .literal(literal),
  .file_rd_data(file_rd_data),
  .file_wr_data(file_wr_data),
  .accum(accum)
);

// file: file_model.sv
// file register array with one-cycle registered read
`timescale 1ns/1ps
module file_model (
  input clock, file_rd_en, file_wr_en,
  input [6:0] file_rd_addr, file_wr_addr,
  input [7:0] file_wr_data,
  output logic [7:0] file_rd_data
);
  logic [7:0] mem [128];
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 5);
  always @(posedge clock)
  begin
    // stale data is inverted, not held
    file_rd_data <= file_rd_en ? mem[file_rd_addr] : ~file_rd_data;
    if (file_wr_en) mem[file_wr_addr] <= file_wr_data;
  end
endmodule // file_model

// file: tb_top.sv
// random bench with a reference model of the datapath
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    tests_run++; \
    if ((a) !== (b)) \
    begin \
      num_errors++; \
      $display("MISMATCH %0t got %0h want %0h", $time, (a), (b)); \
    end \
  end
module tb_top;
  import alu_pkg::*;
  logic clock = 0, reset = 1, start = 0, dest = 0, z = 0;
  logic busy, done, file_rd_en, file_wr_en, zero_flag;
  op_t op = op_none;
  logic [6:0] file_addr = 0, file_rd_addr, file_wr_addr;
  logic [7:0] literal = 0, file_rd_data, file_wr_data, accum, acc = 0, q, f, m [128];
  logic [31:0] s = 92;
  int num_errors = 0, tests_run = 0, k;
  nibble_swap_xor_alu u_nibble_swap_xor_alu (
    .clock(clock),
    .reset(reset),
    .start(start),
    .op(op),
    .dest(dest),
    .file_addr(file_addr),
    .literal(literal),
    .busy(busy),
    .done(done),
    .file_rd_en(file_rd_en),
    .file_rd_addr(file_rd_addr),
    .file_rd_data(file_rd_data),
    .file_wr_en(file_wr_en),
    .file_wr_addr(file_wr_addr),
    .file_wr_data(file_wr_data),
    .accum(accum),
    .zero_flag(zero_flag)
  );
  file_model u_file_model (
    .clock(clock),
    .file_rd_en(file_rd_en),
    .file_wr_en(file_wr_en),
    .file_rd_addr(file_rd_addr),
    .file_wr_addr(file_wr_addr),
    .file_wr_data(file_wr_data),
    .file_rd_data(file_rd_data)
  );
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic results();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial forever #2.5 clock = ~clock;
  initial
  begin
    for (int i = 0; i < 128; i++) m[i] = 8'(i * 5);
    repeat (5) @(posedge clock);
    reset <= 0;
    // a start with no operation is ignored
    @(posedge clock);
    start <= 1;
    @(posedge clock);
    start <= 0;
    @(posedge clock) #1;
    `CHK(busy, 1'b0)
    `CHK(done, 1'b0)
    `CHK(accum, acc)
    repeat (90)
    begin
      @(posedge clock);
      void'(rnd());
      start <= 1;
      op <= op_t'(s[1:0] % 3 + 1);
      dest <= s[8];
      file_addr <= s[15:9];
      literal <= s[16] ? acc : s[31:24];
      @(posedge clock);
      start <= 0;
      for (k = 0; k < 9 && done !== 1'b1; k++)
        @(posedge clock) #1;
      num_errors += k / 9;
      if (k == 9)
        results();
      f = m[file_addr];
      if (op == nibble_exchange_op)
        q = {f[3:0], f[7:4]};
      else if (op == accum_file_xor_op)
        q = acc ^ f;
      else
        q = acc ^ literal;
      if (op != accum_literal_xor_op && dest)
        m[file_addr] = q;
      else
        acc = q;
      if (op != nibble_exchange_op)
        z = q == 8'h00;
      `CHK(accum, acc)
      `CHK(zero_flag, z)
      `CHK(busy, 1'b0)
      `CHK(file_wr_en, op != accum_literal_xor_op && dest)
      if (op != accum_literal_xor_op && dest)
      begin
        `CHK(file_wr_data, q)
        `CHK(file_wr_addr, file_addr)
      end
    end
    results();
  end
endmodule // tb_top
